// [core/ebc_pkg.sv]
// Shared constants and types for the external bus cycle sequencer
package ebc_pkg;
    localparam int ADDR_W     = 24;
    localparam int DATA_W     = 16;
    localparam int CNT_W      = 6;
    localparam int UNIT_W     = 4;
    localparam int WIN_LSB    = 16;
    localparam int WIN_W      = ADDR_W - WIN_LSB;

    localparam logic [CNT_W-1:0]  AB_BASE     = 6'h01;
    localparam logic [CNT_W-1:0]  ACCESS_BASE = 6'h01;
    localparam logic [CNT_W-1:0]  WAIT_LEN    = 6'h01;
    localparam logic [CNT_W-1:0]  CNT_ONE     = 6'h01;
    localparam logic [CNT_W-1:0]  CNT_ZERO    = 6'h00;
    localparam logic [UNIT_W-1:0] UNIT_ZERO   = 4'h0;
    localparam logic [UNIT_W-1:0] UNIT_ONE    = 4'h1;

    localparam logic [ADDR_W-1:0] ADDR_RST    = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_RST    = 16'h0000;
    localparam logic [WIN_W-1:0]  WIN_RST     = 8'h00;

    typedef enum logic [2:0] {
        EBC_IDLE,
        EBC_ADDR,
        EBC_CMD,
        EBC_WDATA,
        EBC_ACCESS,
        EBC_WAIT,
        EBC_HOLD
    } ebc_phase_t;
endpackage

// [core/ebc_tmr_if.sv]
// Link between the sequencer and its phase timer
`timescale 1ns/1ps
interface ebc_tmr_if;
    logic                      load;
    logic [ebc_pkg::CNT_W-1:0] load_val;
    logic [ebc_pkg::UNIT_W-1:0] unit_len;
    logic                      done;

    modport seq (output load, output load_val, output unit_len, input done);
    modport tmr (input load, input load_val, input unit_len, output done);
endinterface

// [core/ebc_phase_timer.sv]
// Phase timer: timing-unit divider plus phase length down counter
`timescale 1ns/1ps
module ebc_phase_timer (
    input  wire logic clock,
    input  wire logic rst_n,
    ebc_tmr_if.tmr    tmr
);
    logic [ebc_pkg::UNIT_W-1:0] div_q;
    logic [ebc_pkg::UNIT_W-1:0] div_d;
    logic [ebc_pkg::CNT_W-1:0]  cnt_q;
    logic [ebc_pkg::CNT_W-1:0]  cnt_d;
    logic [ebc_pkg::UNIT_W-1:0] unit_last;
    logic                       tick;

    always_comb begin
        // A unit length of zero is treated as one system clock
        unit_last = (tmr.unit_len == ebc_pkg::UNIT_ZERO) ? ebc_pkg::UNIT_ZERO
                                                         : tmr.unit_len - ebc_pkg::UNIT_ONE;
        // Independent of load, so done never loops back through the load request
        tick      = (div_q == unit_last);
        tmr.done  = tick && (cnt_q <= ebc_pkg::CNT_ONE); // RULE14
        div_d     = div_q;
        cnt_d     = cnt_q;
        if (tmr.load) begin
            div_d = ebc_pkg::UNIT_ZERO;
            cnt_d = tmr.load_val;
        end else if (tick) begin
            div_d = ebc_pkg::UNIT_ZERO;
            if (cnt_q != ebc_pkg::CNT_ZERO) begin
                cnt_d = cnt_q - ebc_pkg::CNT_ONE; // RULE14
            end
        end else begin
            div_d = div_q + ebc_pkg::UNIT_ONE;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            div_q <= ebc_pkg::UNIT_ZERO;
            cnt_q <= ebc_pkg::CNT_ZERO;
        end else begin
            div_q <= div_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

// [core/ebc_bus_seq.sv]
// External bus cycle sequencer with programmable phases and READY control
`timescale 1ns/1ps
// Functional notes
// (RULE1) Five phases in fixed order every cycle
// (RULE2) Phase lengths come from chip-select timing ports
// (RULE3) READY may stretch access until it allows end
// (RULE4) Address setup lasts one or two units
// (RULE5) Window change adds zero to three units
// (RULE6) Write-data/tristate phase is zero or one unit
// (RULE7) Hold phase is zero to three units
// (RULE8) Command delay 0..3, access 1..32 units
// (RULE9) Reference clock out is system clock, driver enabled
// (RULE10) READY polarity is selectable
// (RULE11) Sync READY direct; async adds synchronizer, wait
// (RULE12) READY inactive adds wait, active ends cycle
// (RULE13) Read data captured as read strobe rises
// (RULE14) Phases counted in whole units, advance on expiry
module ebc_bus_seq (
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    // cs_timing_config fields
    input  wire logic                          addr_setup_len,
    input  wire logic [1:0]                    addr_win_ext,
    input  wire logic [1:0]                    cmd_delay_len,
    input  wire logic                          wdata_setup_len,
    input  wire logic [4:0]                    access_len,
    input  wire logic [1:0]                    hold_len,
    input  wire logic [ebc_pkg::UNIT_W-1:0]    phase_time_unit,
    input  wire logic                          ready_en,
    input  wire logic                          ready_pol,
    input  wire logic                          ready_async,
    // Reference clock pin control
    input  wire logic                          ext_clk_sel_sys,
    input  wire logic                          ext_clk_drv_en,
    output logic                               ext_clock_pin_out,
    output logic                               ext_clock_pin_oe,
    // Request side
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire logic                          req_write,
    input  wire logic [ebc_pkg::ADDR_W-1:0]    req_addr,
    input  wire logic [ebc_pkg::DATA_W-1:0]    req_wdata,
    output logic                               resp_valid,
    output logic [ebc_pkg::DATA_W-1:0]         resp_rdata,
    output logic                               busy,
    // External bus pins
    output logic [ebc_pkg::ADDR_W-1:0]         bus_addr,
    output logic                               bus_ale,
    output logic                               bus_cs_n,
    output logic                               bus_rd_n,
    output logic                               bus_wr_n,
    input  wire logic [ebc_pkg::DATA_W-1:0]    bus_data_in,
    output logic [ebc_pkg::DATA_W-1:0]         bus_data_out,
    output logic                               bus_data_oe,
    input  wire logic                          bus_ready
);
    ebc_tmr_if tmr_if ();

    ebc_phase_timer u_timer (
        .clock (clock),
        .rst_n (rst_n),
        .tmr   (tmr_if.tmr)
    );

    ebc_pkg::ebc_phase_t             state_q;
    ebc_pkg::ebc_phase_t             state_d;
    logic                            write_q;
    logic                            write_d;
    logic [ebc_pkg::ADDR_W-1:0]      addr_q;
    logic [ebc_pkg::ADDR_W-1:0]      addr_d;
    logic [ebc_pkg::DATA_W-1:0]      wdata_q;
    logic [ebc_pkg::DATA_W-1:0]      wdata_d;
    logic [ebc_pkg::DATA_W-1:0]      rdata_q;
    logic [ebc_pkg::DATA_W-1:0]      rdata_d;
    logic                            resp_q;
    logic                            resp_d;
    logic [ebc_pkg::WIN_W-1:0]       win_q;
    logic [ebc_pkg::WIN_W-1:0]       win_d;
    logic                            win_vld_q;
    logic                            win_vld_d;
    logic                            ale_q;
    logic                            cs_n_q;
    logic                            rd_n_q;
    logic                            wr_n_q;
    logic                            doe_q;
    logic                            rdy_s1_q;
    logic                            rdy_s2_q;
    logic                            rdy_seen;
    logic                            finish;
    logic                            load;
    logic [ebc_pkg::CNT_W-1:0]       load_val;

    // Length of a phase in timing units, zero means the phase is skipped
    function automatic logic [ebc_pkg::CNT_W-1:0] phase_len(
        input ebc_pkg::ebc_phase_t ph,
        input logic                win_chg
    );
        logic [ebc_pkg::CNT_W-1:0] len;
        len = ebc_pkg::CNT_ZERO;
        unique case (ph)
            ebc_pkg::EBC_ADDR: begin
                len = ebc_pkg::AB_BASE + {5'h00, addr_setup_len}; // RULE4
                if (win_chg) begin
                    len = len + {4'h0, addr_win_ext}; // RULE5
                end
            end
            ebc_pkg::EBC_CMD:    len = {4'h0, cmd_delay_len}; // RULE8
            ebc_pkg::EBC_WDATA:  len = {5'h00, wdata_setup_len}; // RULE6
            ebc_pkg::EBC_ACCESS: len = ebc_pkg::ACCESS_BASE + {1'b0, access_len}; // RULE8
            ebc_pkg::EBC_WAIT:   len = ebc_pkg::WAIT_LEN;
            ebc_pkg::EBC_HOLD:   len = {4'h0, hold_len}; // RULE7
            ebc_pkg::EBC_IDLE:   len = ebc_pkg::CNT_ZERO;
        endcase
        return len;
    endfunction

    // Next phase in the fixed order, skipping phases programmed to zero
    function automatic ebc_pkg::ebc_phase_t next_phase(input ebc_pkg::ebc_phase_t ph);
        ebc_pkg::ebc_phase_t nx;
        nx = ebc_pkg::EBC_IDLE;
        unique case (ph)
            ebc_pkg::EBC_ADDR: begin
                nx = ebc_pkg::EBC_CMD;
                if (cmd_delay_len == 2'h0) begin
                    nx = wdata_setup_len ? ebc_pkg::EBC_WDATA : ebc_pkg::EBC_ACCESS;
                end
            end
            ebc_pkg::EBC_CMD:
                nx = wdata_setup_len ? ebc_pkg::EBC_WDATA : ebc_pkg::EBC_ACCESS;
            ebc_pkg::EBC_WDATA:  nx = ebc_pkg::EBC_ACCESS;
            ebc_pkg::EBC_ACCESS,
            ebc_pkg::EBC_WAIT:
                nx = (hold_len == 2'h0) ? ebc_pkg::EBC_IDLE : ebc_pkg::EBC_HOLD;
            ebc_pkg::EBC_HOLD:   nx = ebc_pkg::EBC_IDLE;
            ebc_pkg::EBC_IDLE:   nx = ebc_pkg::EBC_IDLE;
        endcase
        return nx;
    endfunction

    // READY after polarity; async mode reads the synchronised copy only
    always_comb begin
        if (ready_async) begin
            rdy_seen = (rdy_s2_q == ready_pol); // RULE10 RULE11
        end else begin
            rdy_seen = (bus_ready == ready_pol); // RULE10 RULE11
        end
    end

    always_comb begin
        state_d   = state_q;
        write_d   = write_q;
        addr_d    = addr_q;
        wdata_d   = wdata_q;
        rdata_d   = rdata_q;
        win_d     = win_q;
        win_vld_d = win_vld_q;
        resp_d    = 1'b0;
        finish    = 1'b0;
        load      = 1'b0;
        load_val  = ebc_pkg::CNT_ZERO;
        unique case (state_q)
            ebc_pkg::EBC_IDLE: begin
                if (req_valid) begin
                    write_d   = req_write;
                    addr_d    = req_addr;
                    wdata_d   = req_wdata;
                    win_d     = req_addr[ebc_pkg::ADDR_W-1:ebc_pkg::WIN_LSB];
                    win_vld_d = 1'b1;
                    state_d   = ebc_pkg::EBC_ADDR; // RULE1
                    load      = 1'b1;
                    load_val  = phase_len(ebc_pkg::EBC_ADDR,
                                          !win_vld_q || (win_q != win_d)); // RULE5
                end
            end
            ebc_pkg::EBC_ACCESS,
            ebc_pkg::EBC_WAIT: begin
                if (tmr_if.done) begin
                    if (!ready_en) begin
                        finish = 1'b1;
                    end else if (ready_async && (state_q == ebc_pkg::EBC_ACCESS)) begin
                        state_d  = ebc_pkg::EBC_WAIT; // RULE11
                        load     = 1'b1;
                        load_val = ebc_pkg::WAIT_LEN;
                    end else if (rdy_seen) begin
                        finish = 1'b1; // RULE3 RULE12
                    end else begin
                        state_d  = ebc_pkg::EBC_WAIT; // RULE3 RULE12
                        load     = 1'b1;
                        load_val = ebc_pkg::WAIT_LEN;
                    end
                end
                if (finish) begin
                    if (!write_q) begin
                        rdata_d = bus_data_in; // RULE13
                    end
                    state_d = next_phase(state_q); // RULE1
                    resp_d  = (state_d == ebc_pkg::EBC_IDLE);
                    if (state_d != ebc_pkg::EBC_IDLE) begin
                        load     = 1'b1;
                        load_val = phase_len(state_d, 1'b0);
                    end
                end
            end
            default: begin
                if (tmr_if.done) begin
                    state_d = next_phase(state_q); // RULE1 RULE14
                    resp_d  = (state_d == ebc_pkg::EBC_IDLE);
                    if (state_d != ebc_pkg::EBC_IDLE) begin
                        load     = 1'b1;
                        load_val = phase_len(state_d, 1'b0); // RULE2
                    end
                end
            end
        endcase
    end

    always_comb begin
        tmr_if.load     = load;
        tmr_if.load_val = load_val;
        tmr_if.unit_len = phase_time_unit; // RULE14
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q   <= ebc_pkg::EBC_IDLE;
            write_q   <= 1'b0;
            addr_q    <= ebc_pkg::ADDR_RST;
            wdata_q   <= ebc_pkg::DATA_RST;
            rdata_q   <= ebc_pkg::DATA_RST;
            resp_q    <= 1'b0;
            win_q     <= ebc_pkg::WIN_RST;
            win_vld_q <= 1'b0;
            ale_q     <= 1'b0;
            cs_n_q    <= 1'b1;
            rd_n_q    <= 1'b1;
            wr_n_q    <= 1'b1;
            doe_q     <= 1'b0;
            rdy_s1_q  <= 1'b0;
            rdy_s2_q  <= 1'b0;
        end else begin
            state_q   <= state_d;
            write_q   <= write_d;
            addr_q    <= addr_d;
            wdata_q   <= wdata_d;
            rdata_q   <= rdata_d;
            resp_q    <= resp_d;
            win_q     <= win_d;
            win_vld_q <= win_vld_d;
            ale_q     <= (state_d == ebc_pkg::EBC_ADDR);
            cs_n_q    <= (state_d == ebc_pkg::EBC_IDLE);
            rd_n_q    <= write_d || !((state_d == ebc_pkg::EBC_ACCESS) ||
                                      (state_d == ebc_pkg::EBC_WAIT)); // RULE13
            wr_n_q    <= !write_d || !((state_d == ebc_pkg::EBC_ACCESS) ||
                                       (state_d == ebc_pkg::EBC_WAIT));
            doe_q     <= write_d && (state_d != ebc_pkg::EBC_IDLE) &&
                         (state_d != ebc_pkg::EBC_ADDR) && (state_d != ebc_pkg::EBC_CMD);
            rdy_s1_q  <= bus_ready; // RULE11
            rdy_s2_q  <= rdy_s1_q;
        end
    end

    // Pin carries the system clock itself when selected and driven
    assign ext_clock_pin_out = ext_clk_sel_sys & clock; // RULE9
    assign ext_clock_pin_oe  = ext_clk_drv_en; // RULE9

    assign req_ready    = (state_q == ebc_pkg::EBC_IDLE);
    assign busy         = (state_q != ebc_pkg::EBC_IDLE);
    assign resp_valid   = resp_q;
    assign resp_rdata   = rdata_q;
    assign bus_addr     = addr_q;
    assign bus_ale      = ale_q;
    assign bus_cs_n     = cs_n_q;
    assign bus_rd_n     = rd_n_q;
    assign bus_wr_n     = wr_n_q;
    assign bus_data_out = wdata_q;
    assign bus_data_oe  = doe_q;
endmodule

// [verif/ebc_bus_seq_chk.sv]
// Bus-pin protocol checker for the bus cycle sequencer
`timescale 1ns/1ps
module ebc_chk (
    input wire logic                       clock,
    input wire logic                       rst_n,
    input wire logic                       ready_en,
    input wire logic                       ext_clk_drv_en,
    input wire logic                       ext_clock_pin_oe,
    input wire logic                       req_valid,
    input wire logic                       req_ready,
    input wire logic [ebc_pkg::ADDR_W-1:0] req_addr,
    input wire logic                       resp_valid,
    input wire logic [ebc_pkg::DATA_W-1:0] resp_rdata,
    input wire logic                       busy,
    input wire logic [ebc_pkg::ADDR_W-1:0] bus_addr,
    input wire logic                       bus_ale,
    input wire logic                       bus_cs_n,
    input wire logic                       bus_rd_n,
    input wire logic                       bus_wr_n,
    input wire logic [ebc_pkg::DATA_W-1:0] bus_data_in,
    input wire logic                       bus_data_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        req_valid && req_ready;
    endsequence
    sequence s_setup;
        bus_ale && !bus_cs_n;
    endsequence
    a_setup_first: assert property (s_take |=> s_setup ##0 bus_addr == $past(req_addr))
        else $error("address setup not first");
    a_cmd_phase: assert property ((!bus_rd_n || !bus_wr_n) |-> !bus_cs_n && !bus_ale)
        else $error("command outside selected cycle");
    a_resp_end: assert property (resp_valid |-> bus_cs_n && bus_rd_n && bus_wr_n)
        else $error("cycle ends with pins active");
    a_clk_drv: assert property (ext_clock_pin_oe == ext_clk_drv_en)
        else $error("clock driver enable wrong");
    a_rd_capture: assert property ($rose(bus_rd_n) |-> resp_rdata == $past(bus_data_in))
        else $error("read data not taken at strobe end");
    a_rd_float: assert property (!bus_rd_n |-> !bus_data_oe && bus_wr_n)
        else $error("data driven during read");
    a_wr_drive: assert property (!bus_wr_n |-> bus_data_oe)
        else $error("write data not driven");
    a_cycle_bound: assert property (s_take ##0 !ready_en |-> ##[3:700] resp_valid)
        else $error("cycle too long");
    a_busy_sel: assert property (busy == !bus_cs_n)
        else $error("busy and chip select disagree");
endmodule

bind ebc_bus_seq ebc_chk i_chk (.clock, .rst_n, .ready_en, .ext_clk_drv_en, .ext_clock_pin_oe,
    .req_valid, .req_ready, .req_addr, .resp_valid, .resp_rdata, .busy, .bus_addr, .bus_ale,
    .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_data_in, .bus_data_oe);

// [verif/ebc_mem_model.sv]
// External memory model with programmable ready response
`timescale 1ns/1ps
module ebc_mem_model (
    input wire logic                       clock,
    input wire logic [ebc_pkg::ADDR_W-1:0] bus_addr,
    input wire logic                       bus_cs_n,
    input wire logic                       bus_rd_n,
    input wire logic                       bus_wr_n,
    input wire logic [ebc_pkg::DATA_W-1:0] bus_data_out,
    input wire logic                       bus_data_oe,
    input wire logic [5:0]                 rdy_dly,
    input wire logic                       ready_pol,
    output logic [ebc_pkg::DATA_W-1:0]     bus_data_in,
    output logic                           bus_ready
);
    logic [ebc_pkg::DATA_W-1:0] mem [16];
    logic [ebc_pkg::DATA_W-1:0] last_q = 16'h0000;
    logic [5:0]                 cnt_q = 6'h00;
    logic                       cmd;
    assign cmd = !bus_cs_n && !(bus_rd_n && bus_wr_n);
    // Released lines toggle so a late capture shows
    assign bus_data_in = (cmd && !bus_rd_n) ? mem[bus_addr[3:0]] : ~last_q;
    // Ready active after rdy_dly command cycles, inactive between cycles
    assign bus_ready = (cmd && cnt_q >= rdy_dly) ? ready_pol : !ready_pol;
    always_ff @(posedge clock) begin
        last_q <= bus_data_in;
        cnt_q <= cmd ? cnt_q + 6'h01 : 6'h00;
        if (cmd && !bus_wr_n && bus_data_oe) begin
            mem[bus_addr[3:0]] <= bus_data_out;
        end
    end
endmodule

// [verif/tb_ebc_bus_seq.sv]
// Self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
module tb_ebc_bus_seq;
    logic        clock, rst_n, addr_setup_len, wdata_setup_len, ready_en, ready_pol, ready_async;
    logic        ext_clk_sel_sys, ext_clk_drv_en, ext_clock_pin_out, ext_clock_pin_oe, req_valid;
    logic        req_ready, req_write, resp_valid, busy, bus_ale, bus_cs_n, bus_rd_n, bus_wr_n;
    logic        bus_data_oe, bus_ready, first;
    logic [1:0]  addr_win_ext, cmd_delay_len, hold_len;
    logic [4:0]  access_len;
    logic [3:0]  phase_time_unit;
    logic [5:0]  rdy_dly;
    logic [7:0]  last_win;
    logic [23:0] req_addr, bus_addr;
    logic [15:0] req_wdata, resp_rdata, bus_data_in, bus_data_out;
    int          error_cnt = 0, cmp_count = 0, cyc = 0, lat;

    ebc_bus_seq i_dut (.clock, .rst_n, .addr_setup_len, .addr_win_ext, .cmd_delay_len,
        .wdata_setup_len, .access_len, .hold_len, .phase_time_unit, .ready_en, .ready_pol,
        .ready_async, .ext_clk_sel_sys, .ext_clk_drv_en, .ext_clock_pin_out, .ext_clock_pin_oe,
        .req_valid, .req_ready, .req_write, .req_addr, .req_wdata, .resp_valid, .resp_rdata,
        .busy, .bus_addr, .bus_ale, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_data_in,
        .bus_data_out, .bus_data_oe, .bus_ready);
    ebc_mem_model i_mem (.clock, .bus_addr, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_data_out,
        .bus_data_oe, .rdy_dly, .ready_pol, .bus_data_in, .bus_ready);

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input bit ok, input string m);
        cmp_count++;
        if (!ok) begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic rdy(input logic en, input logic pol, input logic asy, input logic [5:0] dl);
        ready_en <= en;
        ready_pol <= pol;
        ready_async <= asy;
        rdy_dly <= dl;
    endtask

    task automatic cfg(input logic [3:0] u, input logic ab, input logic [1:0] ex,
                       input logic [1:0] c, input logic d, input logic [4:0] e,
                       input logic [1:0] f);
        phase_time_unit <= u;
        addr_setup_len <= ab;
        addr_win_ext <= ex;
        cmd_delay_len <= c;
        wdata_setup_len <= d;
        access_len <= e;
        hold_len <= f;
        @(posedge clock);
    endtask

    // Issues one cycle; x is the latency expected without ready waits
    task automatic run(input logic wr, input logic [7:0] w, input logic [15:0] wd,
                       output int x);
        x = addr_setup_len + 2 + cmd_delay_len + wdata_setup_len + access_len + hold_len;
        if (first || w != last_win) begin
            x = x + addr_win_ext;
        end
        x = x * ((phase_time_unit == 4'h0) ? 1 : phase_time_unit) + 1;
        first = 1'b0;
        last_win = w;
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= {w, 12'h000, wd[3:0]};
        req_wdata <= wd;
        do @(posedge clock); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        lat = 0;
        do begin
            @(posedge clock);
            lat++;
        end while (resp_valid !== 1'b1 && lat < 3000);
    endtask

    task automatic t_clk;
        ext_clk_sel_sys <= 1'b1;
        ext_clk_drv_en <= 1'b1;
        @(posedge clock);
        #1;
        chk(ext_clock_pin_out === 1'b1 && ext_clock_pin_oe === 1'b1, "clock pin high");
        @(negedge clock);
        #1;
        chk(ext_clock_pin_out === 1'b0, "clock pin low");
        @(posedge clock);
        ext_clk_sel_sys <= 1'b0;
        ext_clk_drv_en <= 1'b0;
        @(posedge clock);
        #1;
        chk(ext_clock_pin_out === 1'b0 && ext_clock_pin_oe === 1'b0, "clock pin off");
        @(posedge clock);
        $display("t_clk done");
    endtask

    task automatic t_phase;
        int x;
        for (int i = 0; i < 4; i++) begin
            cfg(4'(i), i[0], 2'(3 - i), 2'(i), !i[0], (i == 1) ? 5'h1F : 5'(i), 2'(3 - i));
            run(1'b1, 8'(i + 1), 16'hA5C0 + 16'(i), x);
            chk(lat == x, "write latency");
            run(1'b0, 8'(i + 1), 16'hA5C0 + 16'(i), x);
            chk(lat == x, "read latency");
            chk(resp_rdata === 16'hA5C0 + 16'(i), "read data");
        end
        $display("t_phase done");
    endtask

    task automatic t_ready;
        int x;
        for (int k = 0; k < 4; k++) begin
            rdy(1'b1, k[0], 1'b0, k[1] ? 6'h04 : 6'h00);
            cfg(4'h1, 1'b0, 2'h0, 2'h0, 1'b0, 5'h01, 2'h0);
            run(1'b0, 8'h04, 16'hA5C3, x);
            chk(lat == x + (k[1] ? 3 : 0), "ready wait count");
        end
        rdy(1'b0, 1'b1, 1'b0, 6'h28);
        cfg(4'h1, 1'b0, 2'h0, 2'h0, 1'b0, 5'h01, 2'h0);
        run(1'b0, 8'h04, 16'hA5C3, x);
        chk(lat == x, "ready ignored");
        rdy(1'b1, 1'b1, 1'b1, 6'h00);
        cfg(4'h1, 1'b0, 2'h0, 2'h0, 1'b0, 5'h01, 2'h0);
        run(1'b0, 8'h04, 16'hA5C3, x);
        chk(lat > x, "async wait");
        chk(resp_rdata === 16'hA5C3, "async read data");
        $display("t_ready done");
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("BAD %0t timeout", $time);
            test_done();
        end
    end

    initial begin
        rst_n = 1'b0;
        first = 1'b1;
        last_win = 8'h00;
        ext_clk_sel_sys = 1'b0;
        ext_clk_drv_en = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 24'h000000;
        req_wdata = 16'h0000;
        rdy(1'b0, 1'b1, 1'b0, 6'h00);
        cfg(4'h1, 1'b0, 2'h0, 2'h0, 1'b0, 5'h00, 2'h0);
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_clk();
        t_phase();
        t_ready();
        test_done();
    end
endmodule
